/* design/ccregs_bank.v */
// control channel, equalizer and output configuration register bank
`timescale 1ns/1ps
`include "ccregs_defines.vh"
// =====================================================================
module ccregs_bank (
   clk,
   sys_rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   second_port_select,
   floor_enable,
   strap_mode_pin_zero,
   strap_mapsel,
   adaptive_eq_setting0,
   adaptive_eq_setting1,
   spi_cs_n,
   fast_ctrl_channel_mode,
   mode_gpio_count,
   mode_fwd_spi,
   mode_rev_spi,
   clock_edge_polarity,
   spi_launch_rising,
   spi_out_oe,
   eq_setting0,
   eq_setting1,
   eq_adaptive_en0,
   eq_adaptive_en1,
   eq_floor_en,
   equalizer_floor0,
   equalizer_floor1,
   lvds_output_arrangement,
   mapping_mode,
   swing_setting
);
   input  wire        clk;
   input  wire        sys_rst;
   input  wire [7:0]  reg_addr;
   input  wire [7:0]  reg_wdata;
   input  wire        reg_wr;
   input  wire        reg_rd;
   output reg  [7:0]  reg_rdata;
   input  wire        second_port_select;
   input  wire        floor_enable;
   input  wire [2:0]  strap_mode_pin_zero;
   input  wire        strap_mapsel;
   input  wire [5:0]  adaptive_eq_setting0;
   input  wire [5:0]  adaptive_eq_setting1;
   input  wire        spi_cs_n;
   output reg  [2:0]  fast_ctrl_channel_mode;
   output reg  [2:0]  mode_gpio_count;
   output reg         mode_fwd_spi;
   output reg         mode_rev_spi;
   output reg         clock_edge_polarity;
   output wire        spi_launch_rising;
   output wire        spi_out_oe;
   output wire [5:0]  eq_setting0;
   output wire [5:0]  eq_setting1;
   output wire        eq_adaptive_en0;
   output wire        eq_adaptive_en1;
   output wire        eq_floor_en;
   output wire [3:0]  equalizer_floor0;
   output wire [3:0]  equalizer_floor1;
   output reg  [1:0]  lvds_output_arrangement;
   output reg         mapping_mode;
   output wire [1:0]  swing_setting;

   // =====================================================================
   // storage
   reg  [7:0]  bcsc_q;
   reg  [7:0]  bcsc_d;
   reg  [7:0]  oac_q;
   reg  [7:0]  oac_d;
   reg  [7:0]  osc_q;
   reg  [7:0]  osc_d;
   reg         strap_pend_q;
   reg         strap_pend_d;
   reg         mapsel_strap_q;
   reg         mapsel_strap_d;
   reg  [7:0]  rdata_d;
   reg  [2:0]  gpio_count_d;
   wire        wr_bcsc;
   wire        wr_eqmo;
   wire        wr_eqfs;
   wire        wr_oac;
   wire        wr_osc;
   wire [2:0]  chan_mode;
   wire        rev_spi_sel;
   wire        drive_on_select;
   wire        map_override;
   wire        map_reg_val;
   wire        mapping_d;
   wire [15:0] eqmo_all;
   wire [15:0] eqfs_all;
   wire [11:0] adaptive_all;
   wire [11:0] eq_setting_all;
   wire [1:0]  bypass_all;
   wire [7:0]  eqmo_sel;
   wire [5:0]  manual_sel;
   wire [5:0]  adaptive_sel;
   wire [5:0]  eqrb;
   wire [7:0]  rb_bcsc;
   wire [7:0]  rb_eqmo;
   wire [7:0]  rb_eqfs;
   wire [7:0]  rb_oac;
   wire [7:0]  rb_osc;
   wire [7:0]  rb_eqrb;
   genvar      p;

   // =====================================================================
   // write decode
   assign wr_bcsc = reg_wr & (reg_addr == `CCR_ADDR_BCSC);
   assign wr_eqmo = reg_wr & (reg_addr == `CCR_ADDR_EQMO);
   assign wr_eqfs = reg_wr & (reg_addr == `CCR_ADDR_EQFS);
   assign wr_oac  = reg_wr & (reg_addr == `CCR_ADDR_OAC);
   assign wr_osc  = reg_wr & (reg_addr == `CCR_ADDR_OSC);

   // =====================================================================
   // strap capture
   always @* begin
      strap_pend_d   = 1'h0;
      mapsel_strap_d = mapsel_strap_q;
      if (strap_pend_q) begin
         // strap is caught on the first clock after release, not under reset
         mapsel_strap_d = strap_mapsel;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         strap_pend_q   <= 1'h1;
         mapsel_strap_q <= 1'h0;
      end else begin
         strap_pend_q   <= strap_pend_d;
         mapsel_strap_q <= mapsel_strap_d;
      end
   end

   // =====================================================================
   // shared registers
   always @* begin
      bcsc_d = bcsc_q;
      oac_d  = oac_q;
      osc_d  = osc_q;
      if (strap_pend_q) begin
         oac_d[1:0] = strap_mode_pin_zero[1:0];
      end
      if (wr_bcsc) begin
         bcsc_d = reg_wdata & `CCR_BCSC_WMASK;
      end
      if (wr_oac) begin
         // a software write after release beats the strap load
         oac_d = reg_wdata & `CCR_OAC_WMASK;
      end
      if (wr_osc) begin
         osc_d = reg_wdata;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         bcsc_q <= `CCR_RST_BCSC;
         oac_q  <= `CCR_RST_OAC;
         osc_q  <= `CCR_RST_OSC;
      end else begin
         bcsc_q <= bcsc_d;
         oac_q  <= oac_d;
         osc_q  <= osc_d;
      end
   end

   // =====================================================================
   // per-port equalizer controls
   assign adaptive_all = {adaptive_eq_setting1, adaptive_eq_setting0};

   generate
      for (p = 0; p < 2; p = p + 1) begin : g_port
         reg  [7:0] eqmo_q;
         reg  [7:0] eqmo_d;
         reg  [7:0] eqfs_q;
         reg  [7:0] eqfs_d;
         reg  [5:0] eq_set_q;
         reg  [5:0] eq_set_d;
         wire       port_hit;
         wire       mo_hit;
         wire       fs_hit;
         wire [5:0] manual_val;
         wire [5:0] adaptive_val;

         // port 1 is reached only through the select, port 0 otherwise
         assign port_hit     = (p == 1) ? second_port_select : ~second_port_select;
         assign mo_hit       = wr_eqmo & port_hit;
         assign fs_hit       = wr_eqfs & port_hit;
         assign manual_val   = {eqmo_q[3:1], eqmo_q[7:5]};
         assign adaptive_val = adaptive_all[p*6 +: 6];

         always @* begin
            eqmo_d = eqmo_q;
            eqfs_d = eqfs_q;
            if (mo_hit) begin
               eqmo_d = reg_wdata & `CCR_EQMO_WMASK;
            end
            if (fs_hit) begin
               eqfs_d = reg_wdata;
            end
         end

         // manual stages reach the equalizer one clock after the register changes
         always @* begin
            eq_set_d = eqmo_q[`CCR_EQMO_BYP_BIT] ? manual_val : adaptive_val;
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               eqmo_q <= `CCR_RST_EQMO;
               eqfs_q <= `CCR_RST_EQFS;
            end else begin
               eqmo_q <= eqmo_d;
               eqfs_q <= eqfs_d;
            end
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               eq_set_q <= 6'h00;
            end else begin
               eq_set_q <= eq_set_d;
            end
         end

         assign eqmo_all[p*8 +: 8]       = eqmo_q;
         assign eqfs_all[p*8 +: 8]       = eqfs_q;
         assign eq_setting_all[p*6 +: 6] = eq_set_q;
         assign bypass_all[p]            = eqmo_q[`CCR_EQMO_BYP_BIT];
      end
   endgenerate

   assign eq_setting0      = eq_setting_all[5:0];
   assign eq_setting1      = eq_setting_all[11:6];
   assign eq_adaptive_en0  = ~bypass_all[0];
   assign eq_adaptive_en1  = ~bypass_all[1];
   assign eq_floor_en      = floor_enable;
   assign equalizer_floor0 = eqfs_all[3:0];
   assign equalizer_floor1 = eqfs_all[11:8];

   // =====================================================================
   // readback
   assign eqmo_sel     = second_port_select ? eqmo_all[15:8] : eqmo_all[7:0];
   assign manual_sel   = {eqmo_sel[3:1], eqmo_sel[7:5]};
   assign adaptive_sel = second_port_select ? adaptive_eq_setting1 : adaptive_eq_setting0;
   // manual stages reflected only while bypassed
   assign eqrb         = eqmo_sel[`CCR_EQMO_BYP_BIT] ? manual_sel : adaptive_sel;
   // reserved bits are forced to zero here, whatever the storage holds
   assign rb_bcsc      = bcsc_q & `CCR_BCSC_WMASK;
   assign rb_eqmo      = eqmo_sel & `CCR_EQMO_WMASK;
   assign rb_eqfs      = eqfs_all[7:0];
   assign rb_oac       = {mapsel_strap_q, 7'h00} | (oac_q & `CCR_OAC_WMASK);
   assign rb_osc       = osc_q;
   assign rb_eqrb      = {2'h0, eqrb};

   always @* begin
      case (reg_addr)
         `CCR_ADDR_BCSC: rdata_d = rb_bcsc;
         `CCR_ADDR_EQMO: rdata_d = rb_eqmo;
         `CCR_ADDR_EQFS: rdata_d = rb_eqfs;
         `CCR_ADDR_OAC:  rdata_d = rb_oac;
         `CCR_ADDR_OSC:  rdata_d = rb_osc;
         `CCR_ADDR_EQRB: rdata_d = rb_eqrb;
         default:        rdata_d = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // =====================================================================
   // decoded controls
   assign chan_mode       = bcsc_q[2:0];
   assign rev_spi_sel     = (chan_mode == `CCR_MODE_REV_SPI);
   assign drive_on_select = bcsc_q[`CCR_BCSC_DRV_BIT];
   assign map_override    = oac_q[`CCR_OAC_OVR_BIT];
   assign map_reg_val     = oac_q[`CCR_OAC_MAP_BIT];
   assign mapping_d       = map_override ? map_reg_val : mapsel_strap_q;

   // reserved codes fall to none of the modes
   always @* begin
      case (chan_mode)
         `CCR_MODE_GPIO1: gpio_count_d = 3'h1;
         `CCR_MODE_GPIO2: gpio_count_d = 3'h2;
         `CCR_MODE_GPIO4: gpio_count_d = 3'h4;
         default:         gpio_count_d = 3'h0;
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         fast_ctrl_channel_mode <= `CCR_MODE_NORMAL;
         mode_gpio_count        <= 3'h0;
         mode_fwd_spi           <= 1'h0;
         mode_rev_spi           <= 1'h0;
         clock_edge_polarity    <= 1'h0;
      end else begin
         fast_ctrl_channel_mode <= chan_mode;
         mode_gpio_count        <= gpio_count_d;
         mode_fwd_spi           <= (chan_mode == `CCR_MODE_FWD_SPI);
         mode_rev_spi           <= rev_spi_sel;
         clock_edge_polarity    <= bcsc_q[`CCR_BCSC_POL_BIT];
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         lvds_output_arrangement <= 2'h0;
         mapping_mode            <= 1'h0;
      end else begin
         lvds_output_arrangement <= oac_q[1:0];
         mapping_mode            <= mapping_d;
      end
   end

   assign swing_setting     = osc_q[1:0];
   assign spi_launch_rising = bcsc_q[`CCR_BCSC_POL_BIT];
   // tri-state only helps on a shared bus, so it is opt-in
   assign spi_out_oe        = rev_spi_sel & (~drive_on_select | ~spi_cs_n);

endmodule

/* design/ccregs_defines.vh */
// register offsets, field positions and reset values of the control channel register bank
`ifndef CCREGS_DEFINES_VH
`define CCREGS_DEFINES_VH
`define CCR_ADDR_BCSC        8'h43
`define CCR_ADDR_EQMO        8'h44
`define CCR_ADDR_EQFS        8'h45
`define CCR_ADDR_OAC         8'h49
`define CCR_ADDR_OSC         8'h4B
`define CCR_ADDR_EQRB        8'h3B
`define CCR_RST_BCSC         8'h00
`define CCR_RST_EQMO         8'h60
`define CCR_RST_EQFS         8'h08
`define CCR_RST_OSC          8'h08
`define CCR_RST_OAC          8'h00
`define CCR_BCSC_POL_BIT     3
`define CCR_BCSC_DRV_BIT     4
`define CCR_EQMO_BYP_BIT     0
`define CCR_OAC_MAP_BIT      5
`define CCR_OAC_OVR_BIT      6
`define CCR_BCSC_WMASK       8'h1F
`define CCR_EQMO_WMASK       8'hEF
`define CCR_OAC_WMASK        8'h63
`define CCR_MODE_NORMAL      3'h0
`define CCR_MODE_GPIO1       3'h1
`define CCR_MODE_GPIO2       3'h2
`define CCR_MODE_GPIO4       3'h3
`define CCR_MODE_FWD_SPI     3'h6
`define CCR_MODE_REV_SPI     3'h7
`endif

/* dv/ccregs_checker.sv */
// assertion checker for the control channel register bank
`timescale 1ns/1ps
`include "ccregs_defines.vh"
module ccregs_checker (
   input wire       clk,
   input wire       sys_rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       second_port_select,
   input wire [5:0] adaptive_eq_setting0,
   input wire       spi_cs_n,
   input wire [2:0] fast_ctrl_channel_mode,
   input wire [2:0] mode_gpio_count,
   input wire       mode_fwd_spi,
   input wire       mode_rev_spi,
   input wire       spi_out_oe,
   input wire [5:0] eq_setting0,
   input wire       eq_adaptive_en0
);
   // =====
   // helpers: write data delayed to meet the registered outputs
   reg  [7:0] wd_q;
   reg  [7:0] wd_qq;
   wire       wr43 = reg_wr && reg_addr == `CCR_ADDR_BCSC;
   wire       wr44 = reg_wr && reg_addr == `CCR_ADDR_EQMO && !second_port_select;
   always @(posedge clk) begin
      wd_q  <= reg_wdata;
      wd_qq <= wd_q;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // =====
   // assertions
   a_rsvd_mode_bits: assert property (reg_rd && reg_addr == `CCR_ADDR_BCSC |=> reg_rdata[7:5] == 3'h0)
      else $error("reserved mode bits not zero");
   a_gpio_count: assert property (mode_gpio_count == (fast_ctrl_channel_mode == 3'h1 ? 3'h1 :
      fast_ctrl_channel_mode == 3'h2 ? 3'h2 : fast_ctrl_channel_mode == 3'h3 ? 3'h4 : 3'h0)) else $error("gpio count");
   a_spi_decode: assert property (mode_fwd_spi == (fast_ctrl_channel_mode == 3'h6) &&
      mode_rev_spi == (fast_ctrl_channel_mode == 3'h7)) else $error("spi mode decode");
   a_mode_follow: assert property (wr43 ##1 !wr43 |=> fast_ctrl_channel_mode == wd_qq[2:0])
      else $error("mode not taken");
   a_out_enable: assert property (wr43 |=> spi_out_oe == (wd_q[2:0] == 3'h7 && (!wd_q[4] || !spi_cs_n)))
      else $error("data out enable");
   a_bypass_ctl: assert property (wr44 |=> eq_adaptive_en0 == !wd_q[0]) else $error("bypass bit");
   a_eq_adaptive: assert property ($past(eq_adaptive_en0) && !$past(sys_rst) |->
      eq_setting0 == $past(adaptive_eq_setting0)) else $error("adaptive setting not passed");
   a_status_auto: assert property (reg_rd && reg_addr == `CCR_ADDR_EQRB && !second_port_select &&
      eq_adaptive_en0 |=> reg_rdata == {2'h0, $past(adaptive_eq_setting0)}) else $error("status readback");
   c_rev_spi: cover property (wr43 && reg_wdata[2:0] == 3'h7);
   c_bypass: cover property (wr44 && reg_wdata[0]);
   c_status: cover property (reg_rd && reg_addr == `CCR_ADDR_EQRB);
endmodule
bind ccregs_bank ccregs_checker u_chk (.*);

/* dv/testbench.sv */
// self-checking testbench for the control channel register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
   reg        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, second_port_select = 0, floor_enable = 0, spi_cs_n = 1;
   reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   reg  [2:0] strap_mode_pin_zero = 3'h6;
   reg        strap_mapsel = 1;
   reg  [5:0] adaptive_eq_setting0 = 6'h2A, adaptive_eq_setting1 = 6'h15;
   wire [7:0] reg_rdata;
   wire [2:0] fast_ctrl_channel_mode, mode_gpio_count;
   wire       mode_fwd_spi, mode_rev_spi, clock_edge_polarity, spi_launch_rising, spi_out_oe, mapping_mode;
   wire [5:0] eq_setting0, eq_setting1;
   wire       eq_adaptive_en0, eq_adaptive_en1, eq_floor_en;
   wire [3:0] equalizer_floor0, equalizer_floor1;
   wire [1:0] lvds_output_arrangement, swing_setting;
   int        n_errors = 0, tests_run = 0, i;
   ccregs_bank DUT (.*);
   always #5 clk = ~clk;
   // =====
   // bus tasks: strobes launched after a rising edge, one cycle long
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   // registered outputs trail the register by one cycle
   task settle;
      repeat (2) @(negedge clk);
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      summarize;
   end
   // =====
   // tests
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h43, 8'h00);
      rd(8'h44, 8'h60);
      rd(8'h45, 8'h08);
      rd(8'h4B, 8'h08);
      rd(8'h49, 8'h82);
      rd(8'h50, 8'h00);
      rd(8'h3B, 8'h2A);
      `CHK("mapping", 1'b1, mapping_mode)
      `CHK("arrangement", 2'h2, lvds_output_arrangement)
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         if (i < 4 || i > 5) begin
            wr(8'h43, {5'h1C, i[2:0]});
            settle;
            `CHK("mode", i[2:0], fast_ctrl_channel_mode)
            `CHK("gpio", (i == 3) ? 3'h4 : (i < 3) ? i[2:0] : 3'h0, mode_gpio_count)
            `CHK("fwd", i == 6, mode_fwd_spi)
            `CHK("rev", i == 7, mode_rev_spi)
            `CHK("oe", i == 7, spi_out_oe)
            rd(8'h43, {5'h00, i[2:0]});
         end
      end
      wr(8'h43, 8'h1F);
      settle;
      `CHK("oe_cs_high", 1'b0, spi_out_oe)
      `CHK("launch", 1'b1, spi_launch_rising)
      `CHK("polarity", 1'b1, clock_edge_polarity)
      @(posedge clk);
      spi_cs_n <= 1'b0;
      @(negedge clk);
      `CHK("oe_cs_low", 1'b1, spi_out_oe)
      wr(8'h43, 8'h07);
      settle;
      `CHK("launch", 1'b0, spi_launch_rising)
      $display("test channel mode done");
      wr(8'h44, 8'hB5);
      settle;
      `CHK("aen0", 1'b0, eq_adaptive_en0)
      `CHK("eq0", 6'h15, eq_setting0)
      rd(8'h44, 8'hA5);
      rd(8'h3B, 8'h15);
      @(posedge clk);
      second_port_select <= 1'b1;
      wr(8'h44, 8'h61);
      settle;
      `CHK("aen1", 1'b0, eq_adaptive_en1)
      `CHK("eq1", 6'h03, eq_setting1)
      rd(8'h3B, 8'h03);
      wr(8'h45, 8'h05);
      settle;
      `CHK("floor1", 4'h5, equalizer_floor1)
      rd(8'h45, 8'h08);
      @(posedge clk);
      second_port_select <= 1'b0;
      floor_enable <= 1'b1;
      wr(8'h45, 8'hF3);
      settle;
      `CHK("floor0", 4'h3, equalizer_floor0)
      `CHK("floor_en", 1'b1, eq_floor_en)
      rd(8'h45, 8'hF3);
      $display("test equalizer done");
      for (i = 0; i < 4; i++) begin
         wr(8'h49, {6'h10, i[1:0]});
         settle;
         `CHK("arrangement", i[1:0], lvds_output_arrangement)
         `CHK("mapping", 1'b0, mapping_mode)
      end
      wr(8'h49, 8'hFF);
      rd(8'h49, 8'hE3);
      `CHK("mapping", 1'b1, mapping_mode)
      wr(8'h4B, 8'hA6);
      rd(8'h4B, 8'hA6);
      `CHK("swing", 2'h2, swing_setting)
      $display("test output done");
      summarize;
   end
endmodule
